// file: rtl/ofd_pkg.sv
// Package: encodings for the operand field decoder
package ofd_pkg;
   localparam int FIELD_W = 3;
   localparam int REGID_W = 5;
   // Register identifier codes: bytes 0..7, words 8..15, dwords 16..23
   localparam logic [4:0] REG_BYTE_BASE = 5'h00;
   localparam logic [4:0] REG_WORD_BASE = 5'h08;
   localparam logic [4:0] REG_DWORD_BASE = 5'h10;
   localparam logic [4:0] REG_NONE = 5'h1F;
   // Segment codes
   localparam logic [2:0] SEG_EXTRA = 3'h0;
   localparam logic [2:0] SEG_CODE = 3'h1;
   localparam logic [2:0] SEG_STACK = 3'h2;
   localparam logic [2:0] SEG_DATA = 3'h3;
   localparam logic [2:0] SEG_THIRD = 3'h4;
   localparam logic [2:0] SEG_FOURTH = 3'h5;
   localparam logic [2:0] SEG_NONE = 3'h7;
   // Address class and locator codes, and lowest reserved three-bit segment selector
   localparam logic [1:0] CLASS_NODISP = 2'h0;
   localparam logic [1:0] CLASS_DISP8 = 2'h1;
   localparam logic [1:0] CLASS_DISP16 = 2'h2;
   localparam logic [1:0] CLASS_REG = 2'h3;
   localparam logic [2:0] LOC_ESCAPE = 3'h4;
   localparam logic [2:0] LOC_DIRECT16 = 3'h6;
   localparam logic [2:0] LOC_DIRECT32 = 3'h5;
   localparam logic [2:0] SEG3_RSVD_LO = 3'h6;
   // Word register indices used as address components
   localparam logic [2:0] IDX_BASE = 3'h3;
   localparam logic [2:0] IDX_FRAME = 3'h5;
   localparam logic [2:0] IDX_SRC = 3'h6;
   localparam logic [2:0] IDX_DST = 3'h7;
   // Displacement sizes
   typedef enum logic [1:0] {DISP_NONE, DISP_8, DISP_16, DISP_32} ofd_disp_t;
endpackage : ofd_pkg

// file: rtl/ofd_gpr_map.sv
// General-register selector to register identifier
`timescale 1ns/10ps
module ofd_gpr_map
   import ofd_pkg::*;
(
   input wire logic [2:0] sel,
   input wire logic lenPresent,
   input wire logic lenBit,
   input wire logic op32,
   output logic [4:0] regId
);
   always_comb begin
      if (lenPresent && !lenBit) begin
         regId = REG_BYTE_BASE + {2'h0, sel};
      end else if (op32) begin
         regId = REG_DWORD_BASE + {2'h0, sel};
      end else begin
         regId = REG_WORD_BASE + {2'h0, sel};
      end
   end
endmodule : ofd_gpr_map

// file: rtl/ofd_operand_decoder.sv
// Operand field decoder: register, segment and address-mode byte decode
// Behaviour
// - Without length bit, selector picks word or dword register in standard order.
// - 16-bit, length 0: low bytes for 000-011, high bytes for 100-111.
// - 32-bit: length 0 gives same bytes, length 1 gives dword registers.
// - Two-bit segment selector: extra, code, stack, data.
// - Three-bit selector adds third and fourth extra; 110 and 111 reserved.
// - Scaled-index byte follows only under 32-bit addressing, locator 100, class not 11.
// - With scaled-index byte, mode depends on class, scale, index and base.
// - Middle bits are opcode extension or register selector, per opcode.
// - Address-mode byte read at effective address size.
// - Implied-mode instructions skip address-byte decode.
// - 16-bit class 00 forms base/index pairs; locator 110 is displacement alone.
// - 16-bit class 10 adds 16-bit displacement; 110 means frame base plus displacement.
// - Class 11 makes locator a register selector, byte or full operation size by length bit.
// - Length bit 0 means byte, 1 means full operation size.
// - Default sizes from segment attribute; each prefix inverts its size once.
`timescale 1ns/10ps
module ofd_operand_decoder
   import ofd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic insnValid,
   input wire logic [7:0] modeByte,
   input wire logic [7:0] scaledIndexByte,
   input wire logic [2:0] opcodeRegField,
   input wire logic lenPresent,
   input wire logic lenBit,
   input wire logic middleIsReg,
   input wire logic impliedMode,
   input wire logic segmentSizeAttribute,
   input wire logic opSizePrefix,
   input wire logic addrSizePrefix,
   input wire logic [1:0] segSelect2bit,
   input wire logic [2:0] segSelect3bit,
   output logic outValid,
   output logic op32,
   output logic addr32,
   output logic [4:0] opcodeReg,
   output logic [4:0] middleReg,
   output logic [2:0] opcodeExt,
   output logic [4:0] rmReg,
   output logic rmIsReg,
   output logic scaledIndexNeeded,
   output logic [1:0] scaleFactor,
   output logic [4:0] indexReg,
   output logic [4:0] baseReg,
   output logic [4:0] addrBase,
   output logic [4:0] addrIndex,
   output ofd_pkg::ofd_disp_t dispSize,
   output logic [2:0] addrSeg,
   output logic [2:0] segReg2,
   output logic [2:0] segReg3,
   output logic segReserved
);
   import ofd_pkg::*;

   function automatic logic [2:0] seg2_decode(input logic [1:0] s);
      logic [2:0] r;
      r = SEG_EXTRA;
      unique case (s)
         2'h0: r = SEG_EXTRA;
         2'h1: r = SEG_CODE;
         2'h2: r = SEG_STACK;
         2'h3: r = SEG_DATA;
      endcase
      return r;
   endfunction : seg2_decode

   function automatic logic [4:0] word_reg(input logic [2:0] i);
      return REG_WORD_BASE + {2'h0, i};
   endfunction : word_reg

   logic curOp32;
   logic curAddr32;
   logic [1:0] addrClass;
   logic [2:0] locator;
   logic [4:0] opRegId;
   logic [4:0] midRegId;
   logic [4:0] rmRegId;

   // Prefixes toggle the segment's default for this instruction only
   assign curOp32 = segmentSizeAttribute ^ opSizePrefix;
   assign curAddr32 = segmentSizeAttribute ^ addrSizePrefix;
   assign addrClass = modeByte[7:6];
   assign locator = modeByte[2:0];

   ofd_gpr_map uOpReg (
      .sel(opcodeRegField),
      .lenPresent(lenPresent),
      .lenBit(lenBit),
      .op32(curOp32),
      .regId(opRegId)
   );
   ofd_gpr_map uMidReg (
      .sel(modeByte[5:3]),
      .lenPresent(lenPresent),
      .lenBit(lenBit),
      .op32(curOp32),
      .regId(midRegId)
   );
   ofd_gpr_map uRmReg (
      .sel(locator),
      .lenPresent(lenPresent),
      .lenBit(lenBit),
      .op32(curOp32),
      .regId(rmRegId)
   );

   logic nxt_valid;
   logic nxt_op32, nxt_addr32, nxt_rmIsReg, nxt_sibNeeded, nxt_segRsvd;
   logic [4:0] nxt_opcodeReg, nxt_middleReg, nxt_rmReg, nxt_indexReg, nxt_baseReg;
   logic [4:0] nxt_addrBase, nxt_addrIndex;
   logic [2:0] nxt_opcodeExt, nxt_addrSeg, nxt_segReg2, nxt_segReg3;
   logic [1:0] nxt_scale;
   ofd_disp_t nxt_disp;

   always_comb begin
      nxt_valid = insnValid;
      nxt_op32 = curOp32;
      nxt_addr32 = curAddr32;
      nxt_opcodeReg = opRegId;
      // Middle bits either name a register or extend the opcode
      nxt_middleReg = middleIsReg ? midRegId : REG_NONE;
      nxt_opcodeExt = middleIsReg ? 3'h0 : modeByte[5:3];
      nxt_segReg2 = seg2_decode(segSelect2bit);
      nxt_segReg3 = (segSelect3bit[2]) ? ((segSelect3bit[0]) ? SEG_FOURTH : SEG_THIRD)
         : seg2_decode(segSelect3bit[1:0] ^ 2'h0);
      nxt_segRsvd = segSelect3bit >= SEG3_RSVD_LO;
      if (nxt_segRsvd) begin
         nxt_segReg3 = SEG_NONE;
      end
      nxt_rmIsReg = 1'b0;
      nxt_rmReg = REG_NONE;
      nxt_sibNeeded = 1'b0;
      nxt_scale = 2'h0;
      nxt_indexReg = REG_NONE;
      nxt_baseReg = REG_NONE;
      nxt_addrBase = REG_NONE;
      nxt_addrIndex = REG_NONE;
      nxt_disp = DISP_NONE;
      nxt_addrSeg = SEG_NONE;
      if (impliedMode) begin
         // Mode comes from the opcode; addressing bytes are not looked at
         nxt_rmIsReg = 1'b0;
      end else if (addrClass == CLASS_REG) begin
         nxt_rmIsReg = 1'b1;
         nxt_rmReg = rmRegId;
      end else if (curAddr32) begin
         // 32-bit forms beyond the escape are decoded by the address generator
         nxt_sibNeeded = (locator == LOC_ESCAPE);
         if (nxt_sibNeeded) begin
            nxt_scale = scaledIndexByte[7:6];
            nxt_indexReg = REG_DWORD_BASE + {2'h0, scaledIndexByte[5:3]};
            nxt_baseReg = REG_DWORD_BASE + {2'h0, scaledIndexByte[2:0]};
         end
         // Class 00 with locator 101 is a bare 32-bit displacement, so fetch must still pull four bytes
         if (addrClass == CLASS_DISP8) begin
            nxt_disp = DISP_8;
         end else if (addrClass == CLASS_DISP16 || locator == LOC_DIRECT32) begin
            nxt_disp = DISP_32;
         end
      end else begin
         nxt_disp = (addrClass == CLASS_DISP8) ? DISP_8 : (addrClass == CLASS_DISP16) ? DISP_16 : DISP_NONE;
         nxt_addrSeg = SEG_DATA;
         unique case (locator)
            3'h0: begin
               nxt_addrBase = word_reg(IDX_BASE);
               nxt_addrIndex = word_reg(IDX_SRC);
            end
            3'h1: begin
               nxt_addrBase = word_reg(IDX_BASE);
               nxt_addrIndex = word_reg(IDX_DST);
            end
            3'h2: begin
               nxt_addrBase = word_reg(IDX_FRAME);
               nxt_addrIndex = word_reg(IDX_SRC);
               nxt_addrSeg = SEG_STACK;
            end
            3'h3: begin
               nxt_addrBase = word_reg(IDX_FRAME);
               nxt_addrIndex = word_reg(IDX_DST);
               nxt_addrSeg = SEG_STACK;
            end
            3'h4: nxt_addrIndex = word_reg(IDX_SRC);
            3'h5: nxt_addrIndex = word_reg(IDX_DST);
            3'h6: begin
               if (addrClass == CLASS_NODISP) begin
                  nxt_disp = DISP_16;
               end else begin
                  nxt_addrBase = word_reg(IDX_FRAME);
                  nxt_addrSeg = SEG_STACK;
               end
            end
            3'h7: nxt_addrBase = word_reg(IDX_BASE);
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         outValid <= 1'b0;
         op32 <= 1'b0;
         addr32 <= 1'b0;
         opcodeReg <= REG_NONE;
         middleReg <= REG_NONE;
         opcodeExt <= 3'h0;
         rmReg <= REG_NONE;
         rmIsReg <= 1'b0;
         scaledIndexNeeded <= 1'b0;
         scaleFactor <= 2'h0;
         indexReg <= REG_NONE;
         baseReg <= REG_NONE;
         addrBase <= REG_NONE;
         addrIndex <= REG_NONE;
         dispSize <= DISP_NONE;
         addrSeg <= SEG_NONE;
         segReg2 <= SEG_NONE;
         segReg3 <= SEG_NONE;
         segReserved <= 1'b0;
      end else begin
         outValid <= nxt_valid;
         op32 <= nxt_op32;
         addr32 <= nxt_addr32;
         opcodeReg <= nxt_opcodeReg;
         middleReg <= nxt_middleReg;
         opcodeExt <= nxt_opcodeExt;
         rmReg <= nxt_rmReg;
         rmIsReg <= nxt_rmIsReg;
         scaledIndexNeeded <= nxt_sibNeeded;
         scaleFactor <= nxt_scale;
         indexReg <= nxt_indexReg;
         baseReg <= nxt_baseReg;
         addrBase <= nxt_addrBase;
         addrIndex <= nxt_addrIndex;
         dispSize <= nxt_disp;
         addrSeg <= nxt_addrSeg;
         segReg2 <= nxt_segReg2;
         segReg3 <= nxt_segReg3;
         segReserved <= nxt_segRsvd;
      end
   end

   // Sampled rstn keeps the release edge out, where outputs still show reset values one edge later
   sequence s_sibCase;
      rstn && !impliedMode && curAddr32 && locator == LOC_ESCAPE && addrClass != CLASS_REG;
   endsequence
   property p_sib_set;
      @(posedge clk_sys) disable iff (!rstn) s_sibCase |=> scaledIndexNeeded;
   endproperty
   a_sib_set: assert property (p_sib_set) else $error("scaled index not flagged");
   property p_sib_16;
      @(posedge clk_sys) disable iff (!rstn) rstn && !curAddr32 |=> !scaledIndexNeeded;
   endproperty
   a_sib_16: assert property (p_sib_16) else $error("scaled index under 16-bit");
   property p_seg2;
      @(posedge clk_sys) disable iff (!rstn) rstn && segSelect2bit == 2'h0 |=> segReg2 == SEG_EXTRA;
   endproperty
   a_seg2: assert property (p_seg2) else $error("seg2 decode wrong");
   property p_seg3_rsvd;
      @(posedge clk_sys) disable iff (!rstn) rstn && segSelect3bit == 3'h5 |=> segReg3 == SEG_FOURTH && !segReserved;
   endproperty
   a_seg3_rsvd: assert property (p_seg3_rsvd) else $error("seg3 decode wrong");
   property p_bytehigh;
      @(posedge clk_sys) disable iff (!rstn)
         rstn && lenPresent && !lenBit && opcodeRegField == 3'h4 |=> opcodeReg == 5'h04;
   endproperty
   a_bytehigh: assert property (p_bytehigh) else $error("byte reg wrong");
   property p_dword;
      @(posedge clk_sys) disable iff (!rstn) rstn && curOp32 && !lenPresent |=> opcodeReg[4];
   endproperty
   a_dword: assert property (p_dword) else $error("dword not selected");
   property p_direct16;
      @(posedge clk_sys) disable iff (!rstn) rstn && !impliedMode && !curAddr32 && modeByte == 8'h06
         |=> dispSize == DISP_16 && addrBase == REG_NONE && addrSeg == SEG_DATA;
   endproperty
   a_direct16: assert property (p_direct16) else $error("direct 16 wrong");
   property p_frame_disp;
      @(posedge clk_sys) disable iff (!rstn) rstn && !impliedMode && !curAddr32 && modeByte == 8'h86
         |=> addrSeg == SEG_STACK && dispSize == DISP_16;
   endproperty
   a_frame_disp: assert property (p_frame_disp) else $error("frame disp wrong");
   property p_implied;
      @(posedge clk_sys) disable iff (!rstn) rstn && impliedMode |=> !rmIsReg && addrSeg == SEG_NONE;
   endproperty
   a_implied: assert property (p_implied) else $error("implied decoded bytes");
endmodule : ofd_operand_decoder

// file: verif/ofd_fetch_model.sv
// Fetch-side model: presents the address-mode byte and the byte after it
`timescale 1ns/10ps
module ofd_fetch_model (
   input wire logic [7:0] headByte,
   input wire logic [7:0] nextByte,
   output logic [7:0] modeByte,
   output logic [7:0] scaledIndexByte
);
   // Queue head and its follower; no stall, so the decoder sees them at once
   assign modeByte = headByte;
   assign scaledIndexByte = nextByte;
endmodule : ofd_fetch_model

// file: verif/operand_field_decoder_test.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/10ps
module operand_field_decoder_test;
   import ofd_pkg::*;
   logic clk_sys, rstn, insnValid, lenPresent, lenBit, middleIsReg, impliedMode;
   logic segmentSizeAttribute, opSizePrefix, addrSizePrefix;
   logic [7:0] headByte, nextByte, modeByte, scaledIndexByte;
   logic [2:0] opcodeRegField, segSelect3bit, addrSeg, segReg2, segReg3, opcodeExt;
   logic [1:0] segSelect2bit, scaleFactor;
   logic outValid, op32, addr32, rmIsReg, scaledIndexNeeded, segReserved;
   logic [4:0] opcodeReg, middleReg, rmReg, indexReg, baseReg, addrBase, addrIndex;
   ofd_disp_t dispSize;
   logic [15:0] rnd;
   int fails, check_count, cyc;

   ofd_fetch_model ofd_fetch_model_inst (.headByte(headByte), .nextByte(nextByte), .modeByte(modeByte),
      .scaledIndexByte(scaledIndexByte));
   ofd_operand_decoder ofd_operand_decoder_inst (.clk_sys(clk_sys), .rstn(rstn), .insnValid(insnValid),
      .modeByte(modeByte), .scaledIndexByte(scaledIndexByte), .opcodeRegField(opcodeRegField),
      .lenPresent(lenPresent), .lenBit(lenBit), .middleIsReg(middleIsReg), .impliedMode(impliedMode),
      .segmentSizeAttribute(segmentSizeAttribute), .opSizePrefix(opSizePrefix), .addrSizePrefix(addrSizePrefix),
      .segSelect2bit(segSelect2bit), .segSelect3bit(segSelect3bit), .outValid(outValid), .op32(op32),
      .addr32(addr32), .opcodeReg(opcodeReg), .middleReg(middleReg), .opcodeExt(opcodeExt), .rmReg(rmReg),
      .rmIsReg(rmIsReg), .scaledIndexNeeded(scaledIndexNeeded), .scaleFactor(scaleFactor), .indexReg(indexReg),
      .baseReg(baseReg), .addrBase(addrBase), .addrIndex(addrIndex), .dispSize(dispSize), .addrSeg(addrSeg),
      .segReg2(segReg2), .segReg3(segReg3), .segReserved(segReserved));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Register id from a selector; a missing length bit means full size
   function automatic logic [9:0] gpr(input logic [2:0] s, input logic lp, input logic lb, input logic o32);
      if (lp && !lb) return {7'h00, s};
      return o32 ? {5'h00, 2'h2, s} : {5'h00, 2'h1, s};
   endfunction : gpr

   // Order-free pair, since single-register forms may use either slot
   function automatic logic [9:0] srt(input logic [4:0] a, input logic [4:0] b);
      return (a < b) ? {a, b} : {b, a};
   endfunction : srt

   task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic check_all();
      logic o32, a32;
      logic [1:0] cls;
      logic [2:0] loc, mid;
      logic [4:0] b, x;
      o32 = segmentSizeAttribute ^ opSizePrefix;
      a32 = segmentSizeAttribute ^ addrSizePrefix;
      cls = modeByte[7:6];
      mid = modeByte[5:3];
      loc = modeByte[2:0];
      chk("outValid", 10'(outValid), 10'(insnValid));
      chk("op32", 10'(op32), 10'(o32));
      chk("addr32", 10'(addr32), 10'(a32));
      chk("opcodeReg", 10'(opcodeReg), gpr(opcodeRegField, lenPresent, lenBit, o32));
      if (middleIsReg) chk("middleReg", 10'(middleReg), gpr(mid, lenPresent, lenBit, o32));
      else chk("opcodeExt", 10'(opcodeExt), 10'(mid));
      chk("segReg2", 10'(segReg2), 10'(segSelect2bit));
      chk("segReg3", 10'(segReg3), (segSelect3bit >= 3'h6) ? 10'h007 : 10'(segSelect3bit));
      chk("segReserved", 10'(segReserved), 10'(segSelect3bit >= 3'h6));
      if (impliedMode) begin
         chk("sibImplied", 10'(scaledIndexNeeded), 10'h000);
         chk("dispImplied", 10'(dispSize), 10'(DISP_NONE));
      end else begin
         chk("rmIsReg", 10'(rmIsReg), 10'(cls == 2'h3));
         chk("sibNeeded", 10'(scaledIndexNeeded), 10'(a32 && loc == 3'h4 && cls != 2'h3));
         if (cls == 2'h3) begin
            chk("rmReg", 10'(rmReg), gpr(loc, lenPresent, lenBit, o32));
         end else if (a32 && loc == 3'h4) begin
            chk("scale", 10'(scaleFactor), 10'(scaledIndexByte[7:6]));
            chk("indexReg", 10'(indexReg), {7'h02, scaledIndexByte[5:3]});
            chk("baseReg", 10'(baseReg), {7'h02, scaledIndexByte[2:0]});
         end else if (a32) begin
            chk("disp32", 10'(dispSize), (cls == 2'h1) ? 10'(DISP_8) :
               (cls == 2'h2 || loc == 3'h5) ? 10'(DISP_32) : 10'(DISP_NONE));
         end else begin
            b = loc[1] ? 5'h0D : 5'h0B;
            x = loc[0] ? 5'h0F : 5'h0E;
            if (loc[2]) begin
               b = (loc == 3'h6) ? ((cls == 2'h0) ? 5'h1F : 5'h0D) : (loc == 3'h7) ? 5'h0B : x;
               x = 5'h1F;
            end
            chk("addrPair", srt(addrBase, addrIndex), srt(b, x));
            chk("addrSeg", 10'(addrSeg), (b == 5'h0D) ? 10'(SEG_STACK) : 10'(SEG_DATA));
            chk("disp16", 10'(dispSize), (cls == 2'h1) ? 10'(DISP_8) : (cls == 2'h2 || loc == 3'h6) ?
               10'(DISP_16) : 10'(DISP_NONE));
         end
      end
   endtask : check_all

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Sweep plus random tail needs about 1300 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         end_sim();
      end
   end

   initial begin
      {rstn, insnValid, lenPresent, lenBit, middleIsReg, impliedMode} = '0;
      {segmentSizeAttribute, opSizePrefix, addrSizePrefix, headByte, nextByte} = '0;
      {opcodeRegField, segSelect2bit, segSelect3bit} = '0;
      rnd = 16'h0059;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("rstReg", 10'(opcodeReg), 10'(REG_NONE));
      chk("rstSeg", 10'(segReg2), 10'(SEG_NONE));
      chk("rstValid", 10'(outValid), 10'h000);
      $display("test reset done");
      @(posedge clk_sys);
      rstn <= 1'b1;
      // All 256 mode bytes at both default sizes, then random with implied mode
      for (int i = 0; i < 640; i++) begin
         @(posedge clk_sys);
         rnd = lfsr(rnd);
         headByte <= (i < 512) ? i[7:0] : rnd[7:0];
         nextByte <= rnd[15:8];
         opcodeRegField <= rnd[2:0];
         lenPresent <= rnd[3];
         lenBit <= rnd[4];
         middleIsReg <= rnd[5];
         impliedMode <= (i >= 512) && rnd[6];
         segmentSizeAttribute <= (i < 512) ? i[8] : rnd[7];
         opSizePrefix <= rnd[9];
         // Sweep keeps the address size equal to the default so every mode byte meets both sizes
         addrSizePrefix <= (i < 512) ? 1'b0 : rnd[10];
         segSelect2bit <= rnd[12:11];
         segSelect3bit <= rnd[15:13];
         insnValid <= rnd[1] ^ rnd[8];
         @(posedge clk_sys);
         #1;
         check_all();
      end
      $display("test sweep done");
      end_sim();
   end
endmodule : operand_field_decoder_test
